// ==== include/aao_pkg.sv ====
package aao_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned SAMPLE_PERIOD_US = 1000;
    localparam int unsigned SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_US * 1000 * 1000 / CLK_PERIOD_PS;
    localparam int unsigned LPF_FRAC = 10;

    localparam logic [15:0] A_FILTER = 16'h0009;
    localparam logic [15:0] A_PRESENT = 16'h0032;
    localparam logic [15:0] A_STATUS = 16'h0033;
    localparam logic [15:0] A_VOLT = 16'h0034;
    localparam logic [15:0] A_CURR = 16'h0035;
    localparam logic [15:0] A_VMAX = 16'h0036;
    localparam logic [15:0] A_VMIN = 16'h0037;
    localparam logic [15:0] A_IMAX = 16'h0038;
    localparam logic [15:0] A_IMIN = 16'h0039;
    localparam logic [15:0] A_VMODE = 16'h003a;
    localparam logic [15:0] A_IMODE = 16'h003b;
    localparam logic [15:0] A_VRANGE = 16'h003c;
    localparam logic [15:0] A_IRANGE = 16'h003d;
    localparam logic [15:0] A_OSRC = 16'h003e;
    localparam logic [15:0] A_THR = 16'h003f;
    localparam logic [15:0] A_HYST = 16'h0040;
    localparam logic [15:0] B_VPRES = 16'h0320;
    localparam logic [15:0] B_IPRES = 16'h0321;
    localparam logic [15:0] B_VALARM = 16'h0330;
    localparam logic [15:0] B_IALARM = 16'h0331;
    localparam logic [15:0] B_DOUT = 16'h0332;

    // Frame counters: index 0 received, 1 received with error, 2 sent
    localparam int CNT_N = 3;
    localparam logic [15:0] CNT_HI_ADDR [CNT_N] = '{16'h0020, 16'h0022, 16'h0024};
    localparam logic [15:0] CNT_LO_ADDR [CNT_N] = '{16'h0021, 16'h0023, 16'h0025};

    localparam int CFG_N = 12;
    localparam int CI_FILTER = 0;
    localparam int CI_VMAX = 1;
    localparam int CI_VMIN = 2;
    localparam int CI_IMAX = 3;
    localparam int CI_IMIN = 4;
    localparam int CI_VMODE = 5;
    localparam int CI_IMODE = 6;
    localparam int CI_VRANGE = 7;
    localparam int CI_IRANGE = 8;
    localparam int CI_OSRC = 9;
    localparam int CI_THR = 10;
    localparam int CI_HYST = 11;
    localparam logic [15:0] CFG_ADDR [CFG_N] = '{A_FILTER, A_VMAX, A_VMIN, A_IMAX, A_IMIN,
        A_VMODE, A_IMODE, A_VRANGE, A_IRANGE, A_OSRC, A_THR, A_HYST};
    localparam logic [15:0] CFG_RST [CFG_N] = '{16'h0001, 16'h7fff, 16'h8000, 16'h7fff,
        16'h8000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};

    localparam int ST_VALARM = 0;
    localparam int ST_ANY = 1;
    localparam int ST_IALARM = 2;
    localparam int ST_DOUT = 3;
    localparam int PRES_V = 0;
    localparam int PRES_I = 1;
    localparam int OSRC_COOL = 8;

    localparam logic [15:0] FILT_MIN = 16'h0001;
    localparam logic [15:0] FILT_MAX = 16'h000a;
    localparam logic [15:0] MODE_MAX = 16'h0001;
    localparam logic [15:0] VR_OFF = 16'h0000;
    localparam logic [15:0] VR_U10 = 16'h0001;
    localparam logic [15:0] VR_U1 = 16'h0003;
    localparam logic [15:0] VR_MAX = 16'h0004;
    localparam logic [15:0] IR_OFF = 16'h0000;
    localparam logic [15:0] IR_U20 = 16'h0001;
    localparam logic [15:0] IR_420 = 16'h0002;
    localparam logic [15:0] IR_MAX = 16'h0003;
    localparam logic [7:0] OSRC_MASTER = 8'h00;
    localparam logic [7:0] OSRC_VOLT = 8'h01;
    localparam logic [7:0] OSRC_CURR = 8'h02;

    typedef struct packed {
        logic valid;
        logic write;
        logic bit_access;
        logic [15:0] addr;
        logic [15:0] data;
    } aao_req_t;

    typedef struct packed {
        logic valid;
        logic error;
        logic [15:0] data;
    } aao_rsp_t;

    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] current;
        logic volt_present;
        logic curr_present;
    } aao_meas_t;

    typedef struct packed {
        logic frame_tx;
        logic frame_err;
        logic frame_rx;
    } aao_evt_t;

    // Value check applied to every configuration write
    function automatic logic cfg_ok(input int idx, input logic [15:0] d);
        unique case (idx)
            CI_FILTER: return (d >= FILT_MIN) && (d <= FILT_MAX);
            CI_VMODE, CI_IMODE: return d <= MODE_MAX;
            CI_VRANGE: return d <= VR_MAX;
            CI_IRANGE: return d <= IR_MAX;
            CI_OSRC: return (d[15:9] == 7'h00) && (d[7:0] <= OSRC_CURR);
            default: return 1'b1;
        endcase
    endfunction

endpackage

// ==== verilog/aao_lpf.sv ====
`timescale 1ns/1ps
`default_nettype none
module aao_lpf (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_step,
    input wire logic [3:0] i_shift,
    input wire logic [15:0] i_sample,
    output logic [15:0] o_value
);
    import aao_pkg::*;

    localparam int ACC_W = 16 + LPF_FRAC + 1;

    logic signed [ACC_W-1:0] acc_reg;
    logic signed [ACC_W-1:0] target;
    logic signed [ACC_W:0] diff;
    logic signed [ACC_W-1:0] acc_next;
    logic signed [ACC_W-1:0] acc_rnd;

    // First order low-pass: shift sets the time constant in sample ticks
    assign target = ACC_W'($signed({i_sample, {LPF_FRAC{1'b0}}}));
    assign diff = (ACC_W + 1)'(target) - (ACC_W + 1)'(acc_reg);
    assign acc_next = acc_reg + ACC_W'(diff >>> i_shift);
    // Round to nearest so a settled reading equals its input at shifts up to 9
    assign acc_rnd = acc_reg + ACC_W'(1 << (LPF_FRAC - 1));
    assign o_value = acc_rnd[LPF_FRAC +: 16];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            acc_reg <= '0;
        else if (i_step)
            acc_reg <= acc_next;
    end
endmodule // aao_lpf
`default_nettype wire

// ==== verilog/aao_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Presence bits show detected input signals
// - Status bit 3 shows output, writable
// - Voltage above maximum sets alarm bit 1
// - Voltage below minimum sets alarm bit 1
// - Current above maximum sets alarm bit 1
// - Current below minimum sets alarm bit 1
// - Alarm mode: track, or latch until cleared
// - Voltage range codes; zero disables input
// - Current range codes; zero disables input
// - Source zero: output under master control
// - Source one: output follows voltage
// - Source two: output follows current
// - Cooling flag: on above threshold
// - Sixteen bit word registers over port
// - Common filter setting one to ten
// - Error frames counted in 32 bits
module aao_regs #(
    parameter int unsigned SAMPLE_CYCLES = aao_pkg::SAMPLE_CYCLES_DEF,
    parameter logic [15:0] VERSION_ID = 16'h0a01 // Arbitrary value
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire aao_pkg::aao_req_t i_req,
    input wire aao_pkg::aao_meas_t i_meas,
    input wire aao_pkg::aao_evt_t i_evt,
    output aao_pkg::aao_rsp_t o_rsp,
    output logic o_dout
);
    import aao_pkg::*;

    localparam int DIV_W = $clog2(SAMPLE_CYCLES + 1);

    logic [15:0] cfg_reg [CFG_N];
    logic [31:0] cnt_reg [CNT_N];
    logic [1:0] pres_reg;
    logic valarm_reg;
    logic ialarm_reg;
    logic [DIV_W-1:0] div_reg;
    logic tick_reg;
    logic [15:0] filt_out [2];
    logic [15:0] cond_in [2];
    logic [3:0] filt_shift;

    function automatic logic word_wr(input aao_req_t r, input logic [15:0] a);
        return r.valid & r.write & ~r.bit_access & (r.addr == a);
    endfunction

    function automatic logic bit_wr(input aao_req_t r, input logic [15:0] a);
        return r.valid & r.write & r.bit_access & (r.addr == a);
    endfunction

    // Disabled input reads zero, unipolar range clips negatives
    function automatic logic [15:0] condition(input logic [15:0] raw, input logic off,
                                              input logic uni);
        return (off | (uni & raw[15])) ? 16'h0000 : raw;
    endfunction

    // Sample tick for the filters
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= (div_reg == DIV_W'(SAMPLE_CYCLES - 1));
            div_reg <= (div_reg == DIV_W'(SAMPLE_CYCLES - 1)) ? '0 : div_reg + 1'b1;
        end
    end

    wire v_off = cfg_reg[CI_VRANGE] == VR_OFF;
    wire i_off = cfg_reg[CI_IRANGE] == IR_OFF;
    wire v_uni = (cfg_reg[CI_VRANGE] == VR_U10) | (cfg_reg[CI_VRANGE] == VR_U1);
    wire i_uni = (cfg_reg[CI_IRANGE] == IR_U20) | (cfg_reg[CI_IRANGE] == IR_420);
    assign cond_in[0] = condition(i_meas.voltage, v_off, v_uni);
    assign cond_in[1] = condition(i_meas.current, i_off, i_uni);
    assign filt_shift = cfg_reg[CI_FILTER][3:0];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_lpf
            aao_lpf u_lpf (
                .i_sys_clk(i_sys_clk),
                .i_rst(i_rst),
                .i_step(tick_reg),
                .i_shift(filt_shift),
                .i_sample(cond_in[g]),
                .o_value(filt_out[g])
            );
        end
    endgenerate

    wire signed [15:0] v_rd = filt_out[0];
    wire signed [15:0] i_rd = filt_out[1];

    // Alarm conditions against programmed limits
    wire v_hi = ~v_off & (v_rd > $signed(cfg_reg[CI_VMAX]));
    wire v_lo = ~v_off & (v_rd < $signed(cfg_reg[CI_VMIN]));
    wire i_hi = ~i_off & (i_rd > $signed(cfg_reg[CI_IMAX]));
    wire i_lo = ~i_off & (i_rd < $signed(cfg_reg[CI_IMIN]));
    wire v_cond = v_hi | v_lo;
    wire i_cond = i_hi | i_lo;

    wire st_wr = word_wr(i_req, A_STATUS);
    wire va_wr = st_wr | bit_wr(i_req, B_VALARM);
    wire ia_wr = st_wr | bit_wr(i_req, B_IALARM);
    wire do_wr = st_wr | bit_wr(i_req, B_DOUT);
    wire va_wbit = st_wr ? i_req.data[ST_VALARM] : i_req.data[0];
    wire ia_wbit = st_wr ? i_req.data[ST_IALARM] : i_req.data[0];
    wire do_wbit = st_wr ? i_req.data[ST_DOUT] : i_req.data[0];

    // Latched alarm: a new condition wins over a clearing write
    wire valarm_next = cfg_reg[CI_VMODE][0] ? (v_cond | (va_wr ? va_wbit : valarm_reg))
                                            : v_cond;
    wire ialarm_next = cfg_reg[CI_IMODE][0] ? (i_cond | (ia_wr ? ia_wbit : ialarm_reg))
                                            : i_cond;

    // Output switching with hysteresis
    wire [7:0] src = cfg_reg[CI_OSRC][7:0];
    wire cool = cfg_reg[CI_OSRC][OSRC_COOL];
    wire signed [17:0] meas = (src == OSRC_CURR) ? 18'(i_rd) : 18'(v_rd);
    wire signed [17:0] thr = 18'($signed(cfg_reg[CI_THR]));
    wire signed [17:0] hyst = $signed({2'b00, cfg_reg[CI_HYST]});
    wire on_cond = cool ? (meas > thr) : (meas < thr);
    wire off_cond = cool ? (meas < thr - hyst) : (meas > thr + hyst);
    wire auto_next = on_cond ? 1'b1 : (off_cond ? 1'b0 : o_dout);
    wire master_next = do_wr ? do_wbit : o_dout;
    wire dout_next = (src == OSRC_MASTER) ? master_next : auto_next;

    wire [1:0] pres_next = {i_meas.curr_present & ~i_off, i_meas.volt_present & ~v_off};

    wire [15:0] status_word = {12'h000, o_dout, ialarm_reg, valarm_reg | ialarm_reg,
                               valarm_reg};

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            pres_reg <= '0;
            valarm_reg <= 1'b0;
            ialarm_reg <= 1'b0;
            o_dout <= 1'b0;
        end
        else
        begin
            pres_reg <= pres_next;
            valarm_reg <= valarm_next;
            ialarm_reg <= ialarm_next;
            o_dout <= dout_next;
        end
    end

    // Configuration words
    logic [CFG_N-1:0] cfg_hit;
    logic [CFG_N-1:0] cfg_good;
    generate
        for (g = 0; g < CFG_N; g++)
        begin : g_cfg
            assign cfg_hit[g] = word_wr(i_req, CFG_ADDR[g]);
            assign cfg_good[g] = cfg_ok(g, i_req.data);
            always_ff @(posedge i_sys_clk)
            begin
                if (i_rst)
                    cfg_reg[g] <= CFG_RST[g];
                else if (cfg_hit[g] & cfg_good[g])
                    cfg_reg[g] <= i_req.data;
            end
        end
    endgenerate

    // Frame counters: a write loads one half, an event still adds on top
    logic [CNT_N-1:0] evt_vec;
    assign evt_vec = {i_evt.frame_tx, i_evt.frame_err, i_evt.frame_rx};
    generate
        for (g = 0; g < CNT_N; g++)
        begin : g_cnt
            wire hi_wr = word_wr(i_req, CNT_HI_ADDR[g]);
            wire lo_wr = word_wr(i_req, CNT_LO_ADDR[g]);
            wire [31:0] base = {hi_wr ? i_req.data : cnt_reg[g][31:16],
                                lo_wr ? i_req.data : cnt_reg[g][15:0]};
            always_ff @(posedge i_sys_clk)
            begin
                if (i_rst)
                    cnt_reg[g] <= '0;
                else
                    cnt_reg[g] <= base + 32'(evt_vec[g]);
            end
        end
    endgenerate

    // Read and decode of the register port
    logic [15:0] rd_data;
    logic hit;
    logic ro;
    logic bad_val;
    always_comb
    begin
        rd_data = 16'h0000;
        hit = 1'b0;
        ro = 1'b0;
        bad_val = 1'b0;
        if (i_req.bit_access)
        begin
            hit = 1'b1;
            unique case (i_req.addr)
                B_VPRES: begin rd_data[0] = pres_reg[PRES_V]; ro = 1'b1; end
                B_IPRES: begin rd_data[0] = pres_reg[PRES_I]; ro = 1'b1; end
                B_VALARM: rd_data[0] = valarm_reg;
                B_IALARM: rd_data[0] = ialarm_reg;
                B_DOUT: rd_data[0] = o_dout;
                default: hit = 1'b0;
            endcase
        end
        else
        begin
            hit = 1'b1;
            ro = 1'b1;
            unique case (i_req.addr)
                16'h0000: rd_data = VERSION_ID;
                A_PRESENT: rd_data = {14'h0000, pres_reg};
                A_STATUS: begin rd_data = status_word; ro = 1'b0; end
                A_VOLT: rd_data = filt_out[0];
                A_CURR: rd_data = filt_out[1];
                default: hit = 1'b0;
            endcase
            for (int k = 0; k < CFG_N; k++)
            begin
                if (i_req.addr == CFG_ADDR[k])
                begin
                    rd_data = cfg_reg[k];
                    hit = 1'b1;
                    ro = 1'b0;
                    bad_val = ~cfg_good[k];
                end
            end
            for (int k = 0; k < CNT_N; k++)
            begin
                if (i_req.addr == CNT_HI_ADDR[k] || i_req.addr == CNT_LO_ADDR[k])
                begin
                    rd_data = (i_req.addr == CNT_HI_ADDR[k]) ? cnt_reg[k][31:16]
                                                             : cnt_reg[k][15:0];
                    hit = 1'b1;
                    ro = 1'b0;
                end
            end
        end
    end

    wire req_err = ~hit | (i_req.write & (ro | bad_val));

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            o_rsp <= '0;
        else
            o_rsp <= '{valid: i_req.valid, error: i_req.valid & req_err,
                       data: (i_req.valid & hit) ? rd_data : 16'h0000};
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    wire rd_word = i_req.valid & ~i_req.write & ~i_req.bit_access;

    presence_read_a: assert property (
        rd_word && i_req.addr == A_PRESENT |=> o_rsp.data[1:0] == $past(pres_reg))
        else $error("presence read mismatch");
    output_bit_a: assert property (
        rd_word && i_req.addr == A_STATUS |=> o_rsp.data[ST_DOUT] == $past(o_dout))
        else $error("status bit 3 not output state");
    vmax_alarm_a: assert property (
        v_hi |=> valarm_reg && status_word[ST_ANY])
        else $error("high voltage alarm missing");
    vmin_alarm_a: assert property (
        v_lo |=> valarm_reg && status_word[ST_ANY])
        else $error("low voltage alarm missing");
    imax_alarm_a: assert property (
        i_hi |=> ialarm_reg && status_word[ST_ANY])
        else $error("high current alarm missing");
    imin_alarm_a: assert property (
        i_lo |=> ialarm_reg && status_word[ST_ANY])
        else $error("low current alarm missing");
    alarm_latch_a: assert property (
        cfg_reg[CI_VMODE] == 16'h0001 && valarm_reg && !va_wr |=> valarm_reg)
        else $error("latched alarm dropped without write");
    alarm_track_a: assert property (
        cfg_reg[CI_VMODE] == 16'h0000 && !v_cond |=> !valarm_reg)
        else $error("tracking alarm stuck");
    range_off_a: assert property (
        v_off && i_meas.volt_present |=> !pres_reg[PRES_V])
        else $error("disabled input reported present");
    master_hold_a: assert property (
        src == OSRC_MASTER && !do_wr |=> $stable(o_dout))
        else $error("output moved without master write");
    cool_on_a: assert property (
        src != OSRC_MASTER && cool && meas > thr |=> o_dout)
        else $error("cooling output not on");
    heat_on_a: assert property (
        src != OSRC_MASTER && !cool && meas < thr |=> o_dout)
        else $error("heating output not on");
    hyst_hold_a: assert property (
        src != OSRC_MASTER && cool && o_dout && meas >= thr - hyst |=> o_dout)
        else $error("output released inside hysteresis");
    filter_range_a: assert property (
        cfg_reg[CI_FILTER] >= FILT_MIN && cfg_reg[CI_FILTER] <= FILT_MAX)
        else $error("filter setting out of range");
    err_count_a: assert property (
        i_evt.frame_err && !(i_req.valid && i_req.write) |=> cnt_reg[1] == $past(cnt_reg[1]) + 1)
        else $error("error frame not counted");
    unmapped_a: assert property (
        i_req.valid && !hit |=> o_rsp.valid && o_rsp.error)
        else $error("unmapped access not refused");

    latch_clear_c: cover property (valarm_reg && cfg_reg[CI_VMODE][0] ##1 !valarm_reg);
    cool_switch_c: cover property (cool && !o_dout ##1 o_dout);
    master_write_c: cover property (do_wr && src == OSRC_MASTER ##1 o_dout);
    cnt_carry_c: cover property (cnt_reg[1][15:0] == 16'hffff && i_evt.frame_err);
endmodule // aao_regs
`default_nettype wire

// ==== tb/aao_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module aao_master (
    input wire logic i_sys_clk,
    output var aao_pkg::aao_req_t o_req,
    input wire aao_pkg::aao_rsp_t i_rsp
);
    import aao_pkg::*;
    initial o_req = '0;
    // Word or bit transfer; a missing answer shows as an unknown error flag
    task automatic xfer(input logic w, input logic b, input logic [15:0] a,
        input logic [15:0] d, output logic e, output logic [15:0] q);
        @(negedge i_sys_clk);
        o_req = '{valid: 1'b1, write: w, bit_access: b, addr: a, data: d};
        @(negedge i_sys_clk);
        e = i_rsp.valid ? i_rsp.error : 1'bx;
        q = i_rsp.data;
        o_req = '{valid: 1'b0, write: ~w, bit_access: ~b, addr: ~a, data: ~d};
    endtask
endmodule // aao_master
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import aao_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst;
    aao_req_t req;
    aao_rsp_t rsp;
    aao_meas_t meas;
    aao_evt_t evt;
    logic dout;
    logic err;
    logic [15:0] rd;
    int n_errors;
    int checks;

    aao_regs #(.SAMPLE_CYCLES(4)) DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(req),
        .i_meas(meas), .i_evt(evt), .o_rsp(rsp), .o_dout(dout));
    aao_master master (.i_sys_clk(i_sys_clk), .o_req(req), .i_rsp(rsp));

    initial
    begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic wrap_up();
        $display("Errors %0d, comparisons %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic b, input logic [15:0] a,
        input logic [15:0] d, input logic exp_err);
        master.xfer(w, b, a, d, err, rd);
        check({15'h0000, err}, {15'h0000, exp_err}, "error flag");
    endtask

    task automatic rd_chk(input logic b, input logic [15:0] a, input logic [15:0] exp);
        acc(1'b0, b, a, 16'h0000, 1'b0);
        check(rd, exp, "read data");
    endtask

    task automatic wr_settle(input logic [15:0] a, input logic [15:0] d);
        acc(1'b1, 1'b0, a, d, 1'b0);
        repeat (200) @(negedge i_sys_clk);
    endtask

    task automatic dout_chk(input logic exp);
        check({15'h0000, dout}, {15'h0000, exp}, "digital output");
    endtask

    task automatic pulse(input aao_evt_t e, input int n);
        repeat (n)
        begin
            @(negedge i_sys_clk);
            evt = e;
            @(negedge i_sys_clk);
            evt = '0;
        end
    endtask

    task automatic t_reset();
        for (int i = 0; i < CFG_N; i++)
            rd_chk(1'b0, CFG_ADDR[i], CFG_RST[i]);
        dout_chk(1'b0);
    endtask

    task automatic t_refuse();
        acc(1'b1, 1'b0, A_FILTER, 16'h0000, 1'b1);
        acc(1'b1, 1'b0, A_FILTER, 16'h000b, 1'b1);
        acc(1'b1, 1'b0, A_FILTER, 16'h000a, 1'b0);
        rd_chk(1'b0, A_FILTER, 16'h000a);
        acc(1'b1, 1'b0, A_FILTER, 16'h0001, 1'b0);
        acc(1'b1, 1'b0, A_VRANGE, 16'h0005, 1'b1);
        acc(1'b1, 1'b0, A_IRANGE, 16'h0004, 1'b1);
        acc(1'b1, 1'b0, A_VMODE, 16'h0002, 1'b1);
        acc(1'b1, 1'b0, A_PRESENT, 16'h0000, 1'b1);
        acc(1'b0, 1'b0, 16'h0041, 16'h0000, 1'b1);
        check(rd, 16'h0000, "unmapped data");
    endtask

    task automatic t_presence();
        rd_chk(1'b0, A_PRESENT, 16'h0003);
        rd_chk(1'b1, B_VPRES, 16'h0001);
        wr_settle(A_VRANGE, VR_OFF);
        rd_chk(1'b0, A_PRESENT, 16'h0002);
        rd_chk(1'b0, A_VOLT, 16'h0000);
        wr_settle(A_IRANGE, IR_OFF);
        rd_chk(1'b0, A_PRESENT, 16'h0000);
        rd_chk(1'b0, A_CURR, 16'h0000);
        wr_settle(A_VRANGE, VR_U10);
        wr_settle(A_IRANGE, IR_U20);
        rd_chk(1'b0, A_VOLT, 16'h07d0);
        rd_chk(1'b0, A_CURR, 16'h01f4);
    endtask

    task automatic t_alarms();
        wr_settle(A_VMAX, 16'h03e8);
        rd_chk(1'b0, A_STATUS, 16'h0003);
        wr_settle(A_VMAX, 16'h7fff);
        rd_chk(1'b0, A_STATUS, 16'h0000);
        wr_settle(A_VMIN, 16'h0bb8);
        rd_chk(1'b0, A_STATUS, 16'h0003);
        wr_settle(A_VMIN, 16'h8000);
        wr_settle(A_IMAX, 16'h0064);
        rd_chk(1'b0, A_STATUS, 16'h0006);
        wr_settle(A_IMAX, 16'h7fff);
        wr_settle(A_IMIN, 16'h03e8);
        rd_chk(1'b0, A_STATUS, 16'h0006);
        wr_settle(A_IMIN, 16'h8000);
        wr_settle(A_IMODE, 16'h0001);
        wr_settle(A_IMAX, 16'h0064);
        wr_settle(A_IMAX, 16'h7fff);
        rd_chk(1'b1, B_IALARM, 16'h0001);
        acc(1'b1, 1'b1, B_IALARM, 16'h0000, 1'b0);
        rd_chk(1'b0, A_STATUS, 16'h0000);
        wr_settle(A_IMODE, 16'h0000);
        wr_settle(A_VMODE, 16'h0001);
        wr_settle(A_VMAX, 16'h03e8);
        wr_settle(A_VMAX, 16'h7fff);
        rd_chk(1'b0, A_STATUS, 16'h0003);
        acc(1'b1, 1'b0, A_STATUS, 16'h0000, 1'b0);
        rd_chk(1'b1, B_VALARM, 16'h0000);
        wr_settle(A_VMODE, 16'h0000);
    endtask

    task automatic t_output();
        acc(1'b1, 1'b1, B_DOUT, 16'h0001, 1'b0);
        dout_chk(1'b1);
        rd_chk(1'b0, A_STATUS, 16'h0008);
        acc(1'b1, 1'b0, A_STATUS, 16'h0000, 1'b0);
        dout_chk(1'b0);
        wr_settle(A_THR, 16'h0bb8);
        wr_settle(A_OSRC, 16'h0001);
        dout_chk(1'b1);
        acc(1'b1, 1'b1, B_DOUT, 16'h0000, 1'b0);
        dout_chk(1'b1);
        wr_settle(A_OSRC, 16'h0101);
        dout_chk(1'b0);
        wr_settle(A_THR, 16'h03e8);
        dout_chk(1'b1);
        wr_settle(A_HYST, 16'h01f4);
        wr_settle(A_THR, 16'h0960);
        dout_chk(1'b1);
        wr_settle(A_THR, 16'h0a28);
        dout_chk(1'b0);
        wr_settle(A_HYST, 16'h0000);
        wr_settle(A_THR, 16'h03e8);
        wr_settle(A_OSRC, 16'h0002);
        dout_chk(1'b1);
        wr_settle(A_THR, 16'h0064);
        dout_chk(1'b0);
        wr_settle(A_OSRC, 16'h0000);
    endtask

    task automatic t_ranges();
        meas.voltage = 16'hf830;
        wr_settle(A_VRANGE, 16'h0002);
        rd_chk(1'b0, A_VOLT, 16'hf830);
        wr_settle(A_VRANGE, VR_U1);
        rd_chk(1'b0, A_VOLT, 16'h0000);
        meas.current = 16'hfe0c;
        wr_settle(A_IRANGE, IR_MAX);
        rd_chk(1'b0, A_CURR, 16'hfe0c);
        wr_settle(A_IRANGE, IR_420);
        rd_chk(1'b0, A_CURR, 16'h0000);
    endtask

    task automatic t_counters();
        pulse('{frame_tx: 1'b0, frame_err: 1'b1, frame_rx: 1'b0}, 3);
        rd_chk(1'b0, CNT_LO_ADDR[1], 16'h0003);
        rd_chk(1'b0, CNT_HI_ADDR[1], 16'h0000);
        acc(1'b1, 1'b0, CNT_LO_ADDR[1], 16'hffff, 1'b0);
        pulse('{frame_tx: 1'b0, frame_err: 1'b1, frame_rx: 1'b0}, 1);
        rd_chk(1'b0, CNT_LO_ADDR[1], 16'h0000);
        rd_chk(1'b0, CNT_HI_ADDR[1], 16'h0001);
        pulse('{frame_tx: 1'b1, frame_err: 1'b0, frame_rx: 1'b1}, 2);
        rd_chk(1'b0, CNT_LO_ADDR[0], 16'h0002);
        rd_chk(1'b0, CNT_LO_ADDR[2], 16'h0002);
    endtask

    initial
    begin
        n_errors = 0;
        checks = 0;
        i_rst = 1'b1;
        evt = '0;
        meas = '{voltage: 16'h07d0, current: 16'h01f4, volt_present: 1'b1, curr_present: 1'b1};
        repeat (2) @(negedge i_sys_clk);
        i_rst = 1'b0;
        t_reset();
        t_refuse();
        t_presence();
        t_alarms();
        t_output();
        t_ranges();
        t_counters();
        wrap_up();
    end

    // Run needs about 7400 cycles
    initial
    begin
        repeat (40000) @(posedge i_sys_clk);
        n_errors++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
